/* File: dlu_pkg.sv */
// shared constants, types and helpers for the dac load/update control
package dlu_pkg;
    // serial word and buffer shape
    localparam int WORD_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int BITCNT_W = 8;
    localparam logic [7:0] FULL_FRAME_BITS = 8'h10;

    // codes loaded at power-on and by the clear pin
    localparam logic [15:0] CODE_MIDSCALE = 16'h8000;
    localparam logic [15:0] CODE_ZERO = 16'h0000;

    // wake-up delay: typical figure, rounded up to whole cycles
    localparam int SYS_PERIOD_NS = 4;
    localparam int WAKE_TIME_US = 50;
    localparam int WAKE_CYCLES =
        (WAKE_TIME_US * 1000 + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
    localparam int WAKE_CNT_W = 14;

    // positions of the pins inside the synchroniser vectors
    localparam int PIN_CS = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_UPD = 2;
    localparam int PIN_CLR = 3;
    localparam int NUM_PINS = 4;
    // idle levels after reset: select high, clock low, strobe/clear high
    localparam logic [3:0] PIN_IDLE = 4'hD;

    // power sequencing states, gray coded along run-arm-down-wake
    typedef enum logic [1:0] {
        DLU_RUN = 2'h0,
        DLU_ARMED = 2'h1,
        DLU_DOWN = 2'h3,
        DLU_WAKE = 2'h2
    } dlu_pwr_e;

    function automatic logic [7:0] bin2gray(input logic [7:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [7:0] gray2bin(input logic [7:0] g);
        logic [7:0] b;
        b = g;
        for (int i = 6; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : gray2bin
endpackage : dlu_pkg

/* File: dlu_stream_if.sv */
// word stream between the control logic and its buffer
`timescale 1ns/10ps
interface dlu_stream_if #(parameter int W = 16);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;

    modport store (input in_valid, input in_data, input out_ready,
                   output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface : dlu_stream_if

/* File: dlu_fifo.sv */
// small word buffer with registered head and honest full/empty
`timescale 1ns/10ps
module dlu_fifo #(
    parameter int WIDTH = dlu_pkg::WORD_W,
    parameter int DEPTH = dlu_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    dlu_stream_if.store s
);
    // pointers wrap naturally, so depth must be a power of two
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic [WIDTH-1:0] head;
    } dlu_fifo_s;

    dlu_fifo_s q;
    dlu_fifo_s n;
    logic push;
    logic pop;
    logic [AW-1:0] rp_next;

    // handshakes straight from the count
    assign s.in_ready = (q.cnt != FULL);
    assign s.out_valid = (q.cnt != '0);
    assign s.out_data = q.head;

    // head register is refilled from the entry that becomes oldest
    always_comb begin
        n = q;
        push = s.in_valid && (q.cnt != FULL);
        pop = s.out_ready && (q.cnt != '0);
        rp_next = pop ? AW'(q.rp + 1'b1) : q.rp;
        if (push) begin
            n.mem[q.wp] = s.in_data;
            n.wp = AW'(q.wp + 1'b1);
        end
        n.rp = rp_next;
        // bypass: the word written now may be the next head
        if (push && q.wp == rp_next) begin
            n.head = s.in_data;
        end else begin
            n.head = q.mem[rp_next];
        end
        n.cnt = (AW+1)'(q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_fifo_count_up:
    assert property (push && !pop |=> q.cnt == $past(q.cnt) + 1'b1)
        else $error("buffer count did not rise on push");
    a_fifo_first_word:
    assert property (q.cnt == '0 && push |=> s.out_data == $past(s.in_data))
        else $error("first word into empty buffer not at head");
    a_fifo_full_stall:
    assert property (q.cnt == FULL && !pop |=> q.cnt == FULL && !s.in_ready)
        else $error("full buffer took a word");
endmodule : dlu_fifo

/* File: dlu_ctrl.sv */
// serial load, update strobe, clear and shutdown control of a 16-bit dac
//
// Notes on behaviour
// - select low: one data bit sampled per rising serial clock edge
// - strobe held low: select rising moves the word to the output
// - clear pin low forces output register to the variant reset code
// - four-wire: strobe low loads the output, independent of clock; code loads only while select is high
// - after loading, output holds until the strobe goes low
// - parts sharing select and strobe update on the same strobe edge
// - no command word: shutdown only by select and clock edges
// - one clock transition then two select falls enters shutdown
// - one select fall or any clock transition leaves shutdown
// - not ready for 50 us after the waking edge
// - midscale variant powers up with code 8000 hex
// - zero variant powers up with code 0000 hex, chosen at build
`timescale 1ns/10ps
module dlu_ctrl #(
    parameter bit MIDSCALE_VARIANT = 1'b1,
    parameter int WAKE_CYCLES = dlu_pkg::WAKE_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic link_sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic output_update_strobe_n,
    input wire logic hw_reset_code_n,
    output logic [15:0] dac_code,
    output logic shutdown_active,
    output logic converter_ready,
    output logic short_frame
);
    localparam int CS = dlu_pkg::PIN_CS;
    localparam int SK = dlu_pkg::PIN_SCLK;
    localparam int UP = dlu_pkg::PIN_UPD;
    localparam int CL = dlu_pkg::PIN_CLR;
    localparam logic [15:0] RESET_CODE = MIDSCALE_VARIANT ?
        dlu_pkg::CODE_MIDSCALE : dlu_pkg::CODE_ZERO;
    localparam logic [13:0] WAKE_LAST = 14'(WAKE_CYCLES - 1);

    // ---- link side: shift register on the serial clock ----
    typedef struct packed {
        logic [15:0] shreg;
        logic [7:0] bits_g;
    } dlu_link_s;

    dlu_link_s lq;
    dlu_link_s ln;

    // select and data are timed to this clock, so they are read directly
    always_comb begin
        ln = lq;
        if (!cs_n) begin
            ln.shreg = {lq.shreg[14:0], din};
            ln.bits_g = dlu_pkg::bin2gray(
                8'(dlu_pkg::gray2bin(lq.bits_g) + 8'h01));
        end
    end

    // the serial clock stops between frames; reset acts without it
    always_ff @(posedge link_sclk or posedge rst) begin
        if (rst) begin
            lq <= '0;
        end else begin
            lq <= ln;
        end
    end

    // ---- system side ----
    typedef struct packed {
        logic [3:0] p1;
        logic [3:0] p2;
        logic [3:0] p3;
        logic [7:0] g1;
        logic [7:0] g2;
        logic [7:0] start_bits;
        logic end_pend;
        logic [15:0] stage_data;
        logic stage_valid;
        logic [15:0] dac_code;
        dlu_pkg::dlu_pwr_e pwr;
        logic falls;
        logic [13:0] wake_cnt;
        logic ready;
        logic shdn;
        logic short_pulse;
    } dlu_sys_s;

    localparam dlu_sys_s SYS_RST = '{
        p1: dlu_pkg::PIN_IDLE,
        p2: dlu_pkg::PIN_IDLE,
        p3: dlu_pkg::PIN_IDLE,
        g1: 8'h00,
        g2: 8'h00,
        start_bits: 8'h00,
        end_pend: 1'b0,
        stage_data: 16'h0000,
        stage_valid: 1'b0,
        dac_code: RESET_CODE,
        pwr: dlu_pkg::DLU_RUN,
        falls: 1'b0,
        wake_cnt: 14'h0000,
        ready: 1'b1,
        shdn: 1'b0,
        short_pulse: 1'b0
    };

    dlu_sys_s sq;
    dlu_sys_s sn;
    logic cs_fall;
    logic cs_rise;
    logic sclk_chg;
    logic cs_high;
    logic upd_low;
    logic clr_low;
    logic pop_ok;
    logic pop;
    logic frame_full;
    logic [7:0] bits_now;
    logic [7:0] frame_bits;

    dlu_stream_if #(.W(dlu_pkg::WORD_W)) buf_if ();

    dlu_fifo #(
        .WIDTH(dlu_pkg::WORD_W),
        .DEPTH(dlu_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk(sys_clk),
        .rst(rst),
        .s(buf_if.store)
    );

    // staged word waits here while the buffer is full
    assign buf_if.in_valid = sq.stage_valid;
    assign buf_if.in_data = sq.stage_data;
    assign buf_if.out_ready = pop_ok;

    // pin decode from the second and third synchroniser stages
    always_comb begin
        cs_fall = sq.p3[CS] && !sq.p2[CS];
        cs_rise = !sq.p3[CS] && sq.p2[CS];
        sclk_chg = sq.p3[SK] ^ sq.p2[SK];
        cs_high = sq.p2[CS];
        upd_low = !sq.p2[UP];
        clr_low = !sq.p2[CL];
        bits_now = dlu_pkg::gray2bin(sq.g2);
        frame_bits = 8'(bits_now - sq.start_bits);
        frame_full = (frame_bits >= dlu_pkg::FULL_FRAME_BITS);
        // loads only with select high, so a stray strobe cannot tear a word
        pop_ok = upd_low && cs_high && !clr_low;
        pop = pop_ok && buf_if.out_valid;
    end

    // main next-state process
    always_comb begin
        sn = sq;
        sn.short_pulse = 1'b0;
        // two flops per pin; the third stage only feeds edge detection
        sn.p1 = {hw_reset_code_n, output_update_strobe_n, link_sclk, cs_n};
        sn.p2 = sq.p1;
        sn.p3 = sq.p2;
        sn.g1 = lq.bits_g;
        sn.g2 = sq.g1;

        // frame bookkeeping; the end is judged one cycle late so the
        // bit count, which crosses one flop behind, has caught up
        if (cs_fall) begin
            sn.start_bits = bits_now;
        end
        sn.end_pend = cs_rise;

        if (sq.stage_valid && buf_if.in_ready) begin
            sn.stage_valid = 1'b0;
        end
        // shift register is still while select is high, so it is safe
        // to copy across here even though it is a multi-bit word
        if (sq.end_pend) begin
            if (frame_full) begin
                sn.stage_data = lq.shreg;
                sn.stage_valid = 1'b1;
            end else begin
                sn.short_pulse = 1'b1;
            end
        end

        // output register: clear wins over any strobe load
        if (clr_low) begin
            sn.dac_code = RESET_CODE;
        end else if (pop) begin
            // fixed latency from the strobe pin keeps shared parts aligned
            sn.dac_code = buf_if.out_data;
        end
        // otherwise held, also through shutdown

        // power sequencing is pure edge pattern, never a data word
        case (sq.pwr)
            dlu_pkg::DLU_RUN: begin
                if (sclk_chg) begin
                    sn.pwr = dlu_pkg::DLU_ARMED;
                    sn.falls = 1'b0;
                end
            end
            dlu_pkg::DLU_ARMED: begin
                if (sclk_chg) begin
                    sn.falls = 1'b0;
                end else if (cs_fall) begin
                    if (sq.falls) begin
                        sn.pwr = dlu_pkg::DLU_DOWN;
                    end else begin
                        sn.falls = 1'b1;
                    end
                end
            end
            dlu_pkg::DLU_DOWN: begin
                // stays down only while the clock is held and select does not fall
                if (cs_fall || sclk_chg) begin
                    sn.pwr = dlu_pkg::DLU_WAKE;
                    sn.wake_cnt = 14'h0000;
                end
            end
            dlu_pkg::DLU_WAKE: begin
                if (sq.wake_cnt == WAKE_LAST) begin
                    sn.pwr = dlu_pkg::DLU_RUN;
                    sn.falls = 1'b0;
                end else begin
                    sn.wake_cnt = 14'(sq.wake_cnt + 14'h0001);
                end
            end
            default: begin
                sn.pwr = dlu_pkg::DLU_RUN;
            end
        endcase

        sn.ready = (sn.pwr == dlu_pkg::DLU_RUN) ||
                   (sn.pwr == dlu_pkg::DLU_ARMED);
        sn.shdn = (sn.pwr == dlu_pkg::DLU_DOWN);
    end

    // power-on value comes from the variant code in SYS_RST
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sq <= SYS_RST;
        end else begin
            sq <= sn;
        end
    end

    assign dac_code = sq.dac_code;
    assign shutdown_active = sq.shdn;
    assign converter_ready = sq.ready;
    assign short_frame = sq.short_pulse;

    // ---- checks ----
    a_clear_forces_code:
    assert property (@(posedge sys_clk) disable iff (rst)
        clr_low |=> dac_code == RESET_CODE)
        else $error("clear did not force the reset code");

    a_strobe_loads_word:
    assert property (@(posedge sys_clk) disable iff (rst)
        pop && !clr_low |=> dac_code == $past(buf_if.out_data))
        else $error("strobe load did not take the buffered word");

    a_hold_without_strobe:
    assert property (@(posedge sys_clk) disable iff (rst)
        !pop && !clr_low |=> $stable(dac_code))
        else $error("output changed without strobe or clear");

    a_no_load_select_low:
    assert property (@(posedge sys_clk) disable iff (rst)
        !cs_high && !clr_low |=> $stable(dac_code))
        else $error("output loaded with select low");

    a_short_word_dropped:
    assert property (@(posedge sys_clk) disable iff (rst)
        sq.end_pend && !frame_full |=> short_frame && !sq.stage_valid ||
        $past(sq.stage_valid))
        else $error("short frame was not discarded");

    a_two_falls_down:
    assert property (@(posedge sys_clk) disable iff (rst)
        sq.pwr == dlu_pkg::DLU_ARMED && sq.falls && cs_fall && !sclk_chg
        |=> shutdown_active && !converter_ready)
        else $error("two select falls did not enter shutdown");

    a_wake_on_edge:
    assert property (@(posedge sys_clk) disable iff (rst)
        sq.pwr == dlu_pkg::DLU_DOWN && (cs_fall || sclk_chg)
        |=> !shutdown_active && !converter_ready)
        else $error("waking edge did not leave shutdown");

    a_wake_delay_end:
    assert property (@(posedge sys_clk) disable iff (rst)
        sq.pwr == dlu_pkg::DLU_WAKE && sq.wake_cnt == WAKE_LAST
        |=> converter_ready)
        else $error("ready not restored after wake delay");

    a_clock_rearms:
    assert property (@(posedge sys_clk) disable iff (rst)
        sclk_chg && (sq.pwr == dlu_pkg::DLU_RUN ||
        sq.pwr == dlu_pkg::DLU_ARMED)
        |=> sq.pwr == dlu_pkg::DLU_ARMED && !sq.falls)
        else $error("clock change did not restart the fall count");

    a_down_keeps_code:
    assert property (@(posedge sys_clk) disable iff (rst)
        shutdown_active && !clr_low && !pop |=> $stable(dac_code))
        else $error("code lost during shutdown");

    a_frame_to_buffer:
    assert property (@(posedge sys_clk) disable iff (rst)
        sq.end_pend && frame_full |=> sq.stage_valid &&
        sq.stage_data == $past(lq.shreg))
        else $error("full frame not staged");
endmodule : dlu_ctrl

/* File: dlu_host_model.sv */
// host model: drives select, serial clock, data, update strobe and clear
`timescale 1ns/10ps
module dlu_host_model (
    input wire logic sys_clk,
    output logic sclk,
    output logic cs_n,
    output logic din,
    output logic upd_n,
    output logic clr_n
);
    // pins start at their idle levels so reset release sees no edge
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        din = 1'b0;
        upd_n = 1'b1;
        clr_n = 1'b1;
    end

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    // one frame, msb first; the link clock only runs inside the frame
    task automatic shift_frame(input logic [15:0] w, input int n);
        @(posedge sys_clk);
        cs_n <= 1'b0; // strobe is left as the caller set it
        #81.3;
        for (int i = 0; i < n; i++) begin
            din = w[15-i];
            #62.5 sclk = 1'b1;
            #62.5 sclk = 1'b0;
        end
        @(posedge sys_clk);
        cs_n <= 1'b1; // select held low over every bit
        din <= ~din; // released data line must not keep the last bit
        idle(30);
    endtask : shift_frame

    task automatic send_word(input logic [15:0] w);
        shift_frame(w, 16);
    endtask : send_word

    // deliberately short frame of ten bits
    task automatic send_partial(input logic [9:0] w);
        shift_frame({w, 6'h00}, 10);
    endtask : send_partial

    // one lone clock transition arms the shutdown pattern
    task automatic toggle_sclk();
        @(posedge sys_clk);
        #1.7 sclk = ~sclk;
        idle(10);
    endtask : toggle_sclk

    // select pulse with no clock: clock level is left untouched
    task automatic cs_pulse();
        cs_n <= 1'b0;
        idle(12);
        cs_n <= 1'b1;
        idle(30);
    endtask : cs_pulse

    // strobe only ever pulsed while select is high
    task automatic strobe_pulse();
        upd_n <= 1'b0;
        idle(12);
        upd_n <= 1'b1;
        idle(6);
    endtask : strobe_pulse

    task automatic set_strobe(input logic v);
        upd_n <= v;
        idle(6);
    endtask : set_strobe

    task automatic set_clear(input logic v);
        clr_n <= v;
        idle(6);
    endtask : set_clear
endmodule : dlu_host_model

/* File: dlu_ctrl_tb.sv */
// self-checking bench for the dac load, update and shutdown control
`timescale 1ns/10ps
module dlu_ctrl_tb;
    // short wake delay keeps the run brief; expectations derive from it
    localparam int WAKE = 100;
    logic sys_clk = 1'b0;
    logic rst;
    int rst_cnt = 0;
    logic sclk;
    logic cs_n;
    logic din;
    logic upd_n;
    logic clr_n;
    logic [15:0] dac_code;
    logic [15:0] dac_code_z;
    logic shutdown_active;
    logic converter_ready;
    logic short_frame;
    int fails = 0;
    int tests_run = 0;
    int short_seen = 0;

    always #2 sys_clk = ~sys_clk;

    // reset counts four edges; the comb process runs once at time zero,
    // so the rise of reset also reaches the asynchronous link flops
    always @(posedge sys_clk) begin
        if (rst_cnt < 4) begin
            rst_cnt <= rst_cnt + 1;
        end
    end

    always_comb rst = (rst_cnt < 4);

    dlu_host_model host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n),
        .din(din), .upd_n(upd_n), .clr_n(clr_n));

    dlu_ctrl #(.MIDSCALE_VARIANT(1'b1), .WAKE_CYCLES(WAKE)) dut (
        .sys_clk(sys_clk), .rst(rst), .link_sclk(sclk), .cs_n(cs_n),
        .din(din), .output_update_strobe_n(upd_n),
        .hw_reset_code_n(clr_n), .dac_code(dac_code),
        .shutdown_active(shutdown_active),
        .converter_ready(converter_ready), .short_frame(short_frame));

    // second part on the same select and strobe, zero-code variant;
    // only its code is judged, so it keeps the default wake delay
    dlu_ctrl #(.MIDSCALE_VARIANT(1'b0)) dut_z (
        .sys_clk(sys_clk), .rst(rst), .link_sclk(sclk), .cs_n(cs_n),
        .din(din), .output_update_strobe_n(upd_n),
        .hw_reset_code_n(clr_n), .dac_code(dac_code_z),
        .shutdown_active(), .converter_ready(), .short_frame());

    // short_frame stands one cycle only, so count it at every edge
    always @(posedge sys_clk) begin
        if (short_frame === 1'b1) begin
            short_seen <= short_seen + 1;
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (fails == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic t_reset();
        check(dac_code, 16'h8000);
        check(dac_code_z, 16'h0000);
        check({15'h0000, converter_ready}, 16'h0001);
        check({15'h0000, shutdown_active}, 16'h0000);
    endtask : t_reset

    // ten words overrun the buffer; output holds until the strobe
    task automatic t_four_wire();
        host.set_strobe(1'b1);
        for (int i = 0; i < 10; i++) begin
            host.send_word(16'hA5C0 + 16'(i));
        end
        check(dac_code, 16'h8000);
        check({15'h0000, shutdown_active}, 16'h0000);
        host.strobe_pulse();
        check(dac_code, 16'hA5C9);
        check(dac_code_z, 16'hA5C9);
    endtask : t_four_wire

    // strobe held low: each select rise loads directly, back to back
    task automatic t_three_wire();
        host.set_strobe(1'b0);
        host.send_word(16'h1234);
        check(dac_code, 16'h1234);
        host.send_word(16'hFEDC);
        check(dac_code, 16'hFEDC);
        check({15'h0000, shutdown_active}, 16'h0000);
        host.set_strobe(1'b1);
    endtask : t_three_wire

    task automatic t_short();
        int n0;
        n0 = short_seen;
        host.send_partial(10'h3FF);
        check(16'(short_seen - n0), 16'h0001);
        host.strobe_pulse();
        check(dac_code, 16'hFEDC);
    endtask : t_short

    task automatic t_clear();
        host.set_clear(1'b0);
        check(dac_code, 16'h8000);
        check(dac_code_z, 16'h0000);
        host.set_clear(1'b1);
    endtask : t_clear

    task automatic enter_shutdown();
        host.toggle_sclk();
        host.cs_pulse();
        host.cs_pulse();
        check({15'h0000, shutdown_active}, 16'h0001);
        check({15'h0000, converter_ready}, 16'h0000);
    endtask : enter_shutdown

    // wake once by select and once by clock; the code survives both
    task automatic t_shutdown();
        host.set_strobe(1'b0);
        host.send_word(16'h0F0F);
        host.set_strobe(1'b1);
        enter_shutdown();
        host.idle(40);
        check({15'h0000, shutdown_active}, 16'h0001);
        host.cs_pulse();
        check({15'h0000, shutdown_active}, 16'h0000);
        host.idle(WAKE - 50);
        check({15'h0000, converter_ready}, 16'h0000);
        host.idle(20);
        check({15'h0000, converter_ready}, 16'h0001);
        check(dac_code, 16'h0F0F);
        enter_shutdown();
        host.toggle_sclk();
        check({15'h0000, shutdown_active}, 16'h0000);
        host.idle(WAKE + 10);
        check({15'h0000, converter_ready}, 16'h0001);
        check(dac_code, 16'h0F0F);
    endtask : t_shutdown

    initial begin
        repeat (4) @(posedge sys_clk);
        host.idle(4);
        t_reset();
        t_four_wire();
        t_three_wire();
        t_short();
        t_clear();
        t_shutdown();
        end_of_test();
    end

    // whole run needs about 8000 cycles; allow six times that
    initial begin
        #200000;
        fails++;
        end_of_test();
    end
endmodule : dlu_ctrl_tb
